// File: include/fsk_pkg.sv
`default_nettype none
package fsk_pkg;
	// rates
	localparam int unsigned CLK_HZ      = 100_000_000;
	localparam int unsigned BAUD_HZ     = 1200;
	localparam int unsigned OVS         = 16;
	localparam int unsigned TICK_CYCLES = CLK_HZ / (BAUD_HZ * OVS);
	localparam int unsigned TICK_W      = 16;

	// bit cell timing in oversample ticks, word length in bits
	localparam logic [3:0] PH_LAST      = 4'hF;
	localparam logic [3:0] PH_HALF      = 4'h7;
	localparam logic [3:0] BIT_LAST     = 4'h7;
	localparam logic [3:0] BITS_PER_WORD = 4'h8;

	// carrier qualification and hold, in microseconds and ticks
	localparam int unsigned CD_QUALIFY_US = 1000;
	localparam int unsigned CD_HOLD_US    = 8000;
	localparam int unsigned CD_QUAL_TICKS = (CD_QUALIFY_US * BAUD_HZ * OVS + 999_999) / 1_000_000;
	localparam int unsigned CD_HOLD_TICKS = (CD_HOLD_US * BAUD_HZ * OVS) / 1_000_000;
	localparam logic [7:0]  CD_QUAL_LAST  = 8'(CD_QUAL_TICKS - 1);
	localparam logic [7:0]  CD_HOLD_LAST  = 8'(CD_HOLD_TICKS - 1);

	// synchronised pin vector layout
	localparam int unsigned SYN_W     = 11;
	localparam int unsigned SY_MODE   = 0;
	localparam int unsigned SY_DEMOD  = 1;
	localparam int unsigned SY_ENERGY = 2;
	localparam int unsigned SY_HCLK   = 3;
	localparam int unsigned SY_PD     = 4;
	localparam int unsigned SY_TLOW   = 5;
	localparam int unsigned SY_THIGH  = 6;
	localparam int unsigned SY_GUARD  = 7;
	localparam int unsigned SY_TRIG   = 8;
	localparam int unsigned SY_TIMING = 9;
	localparam int unsigned SY_DEMEN  = 10;

	// register map
	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_WORD   = 12'h008;
	localparam logic [11:0] REG_COUNT  = 12'h00C;
	localparam logic        CTRL_RESET = 1'b1;

	// receiver states
	typedef enum logic [3:0] {
		RX_IDLE  = 4'h1,
		RX_START = 4'h2,
		RX_DATA  = 4'h4,
		RX_STOP  = 4'h8
	} rx_state_e;
endpackage
`default_nettype wire

// File: src/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
	parameter int unsigned WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// pins and synchronised levels
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level_out
);
	logic [WIDTH-1:0] meta_q;

	// two flops per pin; the first stage feeds only the second
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta_q[i]    <= 1'b0;
					level_out[i] <= 1'b0;
				end else begin
					meta_q[i]    <= pin_in[i];
					level_out[i] <= meta_q[i];
				end
			end
		end
	endgenerate
endmodule // pin_sync
`default_nettype wire

// File: src/fsk_word_serial_output.sv
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module fsk_word_serial_output #(
	parameter int unsigned TICK_CYCLES = fsk_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RST_N,
	// apb slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// demodulator and detector levels
	input  wire logic        DEMOD_BIT,
	input  wire logic        FSK_BAND_ENERGY,
	input  wire logic        TONE_LOW_PRESENT,
	input  wire logic        TONE_HIGH_PRESENT,
	input  wire logic        GUARD_TIME_NODE,
	// host pins
	input  wire logic        INTERFACE_SEL,
	input  wire logic        DEMODULATOR_ENABLE,
	input  wire logic        POWER_DOWN_IN,
	input  wire logic        SERIAL_BIT_CLOCK_IN,
	output logic             SERIAL_BIT_CLOCK_OUT,
	output logic             SERIAL_BIT_CLOCK_OE,
	output logic             SERIAL_DATA,
	output logic             WORD_READY_N,
	output logic             CARRIER_PRESENT_N,
	output logic             RAW_TONE_DETECT,
	output logic             QUALIFIED_TONE_DETECT,
	// call alert path
	input  wire logic        CALL_ALERT_IN,
	input  wire logic        CALL_ALERT_TIMING,
	output logic             CALL_ALERT_DISCHARGE,
	output logic             CALL_ALERT_OUT_N,
	// open-drain interrupt
	output logic             INT_OUT,
	output logic             INT_OE
);
	logic [fsk_pkg::SYN_W-1:0] syn;
	logic [fsk_pkg::TICK_W-1:0] tick_cnt_q;
	logic                      tick;
	fsk_pkg::rx_state_e        state_q;
	logic [3:0]                phase_q;
	logic [3:0]                bit_idx_q;
	logic [7:0]                word_q;
	logic                      sclk_q;
	logic                      data_q;
	logic                      ready_n_q;
	logic [3:0]                ready_cnt_q;
	logic [7:0]                shift_q;
	logic [3:0]                remain_q;
	logic                      hclk_prev_q;
	logic                      cd_n_q;
	logic [7:0]                cd_cnt_q;
	logic                      raw_q;
	logic                      qual_q;
	logic                      trig_out_n_q;
	logic                      trig_dis_q;
	logic                      oe_q;
	logic                      enable_q;
	logic [7:0]                last_word_q;
	logic [15:0]               count_q;
	logic [31:0]               prdata_q;

	// pin synchronisers
	pin_sync #(
		.WIDTH(fsk_pkg::SYN_W)
	) u_sync (
		.clk      (CLK),
		.rst_n    (RST_N),
		.pin_in   ({DEMODULATOR_ENABLE, CALL_ALERT_TIMING, CALL_ALERT_IN, GUARD_TIME_NODE,
		            TONE_HIGH_PRESENT, TONE_LOW_PRESENT, POWER_DOWN_IN, SERIAL_BIT_CLOCK_IN,
		            FSK_BAND_ENERGY, DEMOD_BIT, INTERFACE_SEL}),
		.level_out(syn)
	);

	// named pin levels and decodes
	wire halt       = syn[fsk_pkg::SY_PD];
	wire mode1      = syn[fsk_pkg::SY_MODE];
	wire rx_bit     = syn[fsk_pkg::SY_DEMOD];
	wire energy     = syn[fsk_pkg::SY_ENERGY];
	wire rx_open    = !cd_n_q && enable_q && syn[fsk_pkg::SY_DEMEN] && !halt;
	wire host_rise  = mode1 && syn[fsk_pkg::SY_HCLK] && !hclk_prev_q;
	wire centre     = tick && (phase_q == fsk_pkg::PH_LAST);
	wire half_pt    = tick && (phase_q == fsk_pkg::PH_HALF);
	wire start_mid  = (state_q == fsk_pkg::RX_START) && half_pt;
	wire data_smp   = (state_q == fsk_pkg::RX_DATA) && centre && rx_open;  // carrier loss gates the sample
	wire last_bit   = data_smp && (bit_idx_q == fsk_pkg::BIT_LAST);
	wire stop_ok    = (state_q == fsk_pkg::RX_STOP) && centre && rx_bit && rx_open;
	wire m1_load    = last_bit && mode1;
	wire m0_done    = stop_ok && !mode1;
	wire [7:0] word_next = {rx_bit, word_q[7:1]};
	wire shift_go   = host_rise && (remain_q != 4'h0);
	wire ready_end  = tick && (ready_cnt_q == fsk_pkg::PH_HALF);
	wire tick_last  = (tick_cnt_q == fsk_pkg::TICK_W'(TICK_CYCLES - 1));

	// oversample tick enable at sixteen per 1200 baud bit; stops in power-down
	assign tick = tick_last && !halt;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			tick_cnt_q <= '0;
		end else if (halt || tick_last) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
		end
	end

	// carrier qualify / hold counter; one counter serves both directions
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cd_n_q   <= 1'b1;
			cd_cnt_q <= '0;
		end else if (halt) begin
			cd_n_q   <= 1'b1;
			cd_cnt_q <= '0;
		end else if (tick) begin
			if (cd_n_q) begin
				if (!energy) begin
					cd_cnt_q <= '0;
				end else if (cd_cnt_q == fsk_pkg::CD_QUAL_LAST) begin
					cd_n_q   <= 1'b0;
					cd_cnt_q <= '0;
				end else begin
					cd_cnt_q <= cd_cnt_q + 1'b1;
				end
			end else begin
				if (energy) begin
					cd_cnt_q <= '0;
				end else if (cd_cnt_q == fsk_pkg::CD_HOLD_LAST) begin
					cd_n_q   <= 1'b1;
					cd_cnt_q <= '0;
				end else begin
					cd_cnt_q <= cd_cnt_q + 1'b1;
				end
			end
		end
	end

	// word recovery: start edge, mid-start check, eight data centres, stop centre
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q   <= fsk_pkg::RX_IDLE;
			phase_q   <= '0;
			bit_idx_q <= '0;
			word_q    <= '0;
		end else if (halt || !rx_open) begin
			state_q   <= fsk_pkg::RX_IDLE;
			phase_q   <= '0;
			bit_idx_q <= '0;
		end else begin
			if (tick) begin
				phase_q <= phase_q + 1'b1;
			end
			case (state_q)
				fsk_pkg::RX_IDLE: begin
					phase_q <= '0;
					if (!rx_bit) begin
						state_q <= fsk_pkg::RX_START;
					end
				end
				fsk_pkg::RX_START: begin
					if (start_mid) begin
						state_q   <= rx_bit ? fsk_pkg::RX_IDLE : fsk_pkg::RX_DATA;
						phase_q   <= '0;                                    // a full bit from mid-start
						bit_idx_q <= '0;
					end
				end
				fsk_pkg::RX_DATA: begin
					if (data_smp) begin
						word_q    <= word_next;
						bit_idx_q <= bit_idx_q + 1'b1;
						if (last_bit) begin
							state_q <= fsk_pkg::RX_STOP;
						end
					end
				end
				fsk_pkg::RX_STOP: begin
					if (centre) begin
						state_q <= fsk_pkg::RX_IDLE;                        // in mode 0 a bad stop bit drops the word
					end
				end
				default: begin
					state_q <= fsk_pkg::RX_IDLE;
				end
			endcase
		end
	end

	// mode 0 bit clock: rises at each data centre, falls half a bit later
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sclk_q <= 1'b0;
		end else if (halt || mode1 || !rx_open) begin
			sclk_q <= 1'b0;                                                 // never left high on carrier loss
		end else if (data_smp) begin
			sclk_q <= 1'b1;
		end else if (half_pt) begin
			sclk_q <= 1'b0;
		end
	end

	// word-ready: low half a bit, or until the first host read clock in mode 1
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ready_n_q   <= 1'b1;
			ready_cnt_q <= '0;
		end else if (halt) begin
			ready_n_q   <= 1'b1;
			ready_cnt_q <= '0;
		end else if (m1_load || m0_done) begin
			ready_n_q   <= 1'b0;
			ready_cnt_q <= '0;
		end else if (!ready_n_q && (host_rise || ready_end)) begin
			ready_n_q   <= 1'b1;
		end else if (tick) begin
			ready_cnt_q <= ready_cnt_q + 1'b1;
		end
	end

	// mode 1 output shift register; loads never happen without carrier
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			shift_q     <= '0;
			remain_q    <= '0;
			hclk_prev_q <= 1'b0;
		end else begin
			hclk_prev_q <= syn[fsk_pkg::SY_HCLK];
			if (m1_load) begin
				shift_q  <= word_next;
				remain_q <= fsk_pkg::BITS_PER_WORD;
			end else if (shift_go) begin
				shift_q  <= {1'b0, shift_q[7:1]};
				remain_q <= remain_q - 1'b1;
			end
		end
	end

	// serial data pin: live stream in mode 0, shifted word in mode 1
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			data_q <= 1'b1;
		end else if (!mode1) begin
			data_q <= rx_open && !halt ? rx_bit : 1'b1;
		end else if (shift_go) begin
			data_q <= shift_q[0];
		end
	end

	// tone detect outputs and the alert path; the alert path ignores power-down
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			raw_q        <= 1'b0;
			qual_q       <= 1'b0;
			trig_out_n_q <= 1'b1;
			trig_dis_q   <= 1'b0;
			oe_q         <= 1'b0;
		end else begin
			raw_q        <= !halt && syn[fsk_pkg::SY_TLOW] && syn[fsk_pkg::SY_THIGH];
			qual_q       <= !halt && syn[fsk_pkg::SY_GUARD];
			trig_dis_q   <= syn[fsk_pkg::SY_TRIG];
			trig_out_n_q <= syn[fsk_pkg::SY_TIMING];
			oe_q         <= !mode1;
		end
	end

	// software side: control, last word, character count
	wire acc      = PSEL && PENABLE;
	wire setup    = PSEL && !PENABLE;
	wire hit_ctrl = (PADDR == fsk_pkg::REG_CTRL);
	wire hit_stat = (PADDR == fsk_pkg::REG_STATUS);
	wire hit_word = (PADDR == fsk_pkg::REG_WORD);
	wire hit_cnt  = (PADDR == fsk_pkg::REG_COUNT);
	wire mapped   = hit_ctrl || hit_stat || hit_word || hit_cnt;
	wire got_word = m0_done || m1_load;
	wire cnt_clr  = acc && PWRITE && hit_cnt;
	wire [31:0] status_w = {26'h0000000, halt, qual_q, raw_q, !ready_n_q, mode1, !cd_n_q};
	wire [31:0] rd_mux   = hit_ctrl ? {31'h00000000, enable_q} :
	                       hit_stat ? status_w :
	                       hit_word ? {24'h000000, last_word_q} :
	                       hit_cnt  ? {16'h0000, count_q} : 32'h00000000;

	// register writes; a clear and a new character in the same cycle leave a count of one
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			enable_q    <= fsk_pkg::CTRL_RESET;
			last_word_q <= '0;
			count_q     <= '0;
			prdata_q    <= '0;
		end else begin
			if (acc && PWRITE && hit_ctrl) begin
				enable_q <= PWDATA[0];
			end
			if (got_word) begin
				last_word_q <= m1_load ? word_next : word_q;
				count_q     <= cnt_clr ? 16'h0001 : count_q + 1'b1;
			end else if (cnt_clr) begin
				count_q <= '0;
			end
			if (setup) begin
				prdata_q <= PWRITE ? 32'h00000000 : rd_mux;
			end
		end
	end

	// outputs
	assign PRDATA                = prdata_q;
	assign PREADY                = 1'b1;                                    // zero wait states
	assign PSLVERR               = acc && !mapped;
	assign SERIAL_BIT_CLOCK_OUT  = sclk_q;
	assign SERIAL_BIT_CLOCK_OE   = oe_q;
	assign SERIAL_DATA           = data_q;
	assign WORD_READY_N          = ready_n_q;
	assign CARRIER_PRESENT_N     = cd_n_q;
	assign RAW_TONE_DETECT       = raw_q;
	assign QUALIFIED_TONE_DETECT = qual_q;
	assign CALL_ALERT_DISCHARGE  = trig_dis_q;
	assign CALL_ALERT_OUT_N      = trig_out_n_q;
	assign INT_OUT               = 1'b0;
	assign INT_OE                = !trig_out_n_q || qual_q || !ready_n_q;

	// checks
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	a_oe_follows_mode:  assert property (!mode1 |=> oe_q) else $error("bit clock not driven in mode 0");
	a_host_mode_oe:     assert property (mode1 |=> !oe_q) else $error("bit clock driven in mode 1");
	a_clk_rise_data:    assert property ($rose(sclk_q) |-> $past(state_q) == fsk_pkg::RX_DATA)
		else $error("bit clock rose outside data cells");
	a_clk_per_bit:      assert property (data_smp && !mode1 |=> sclk_q && bit_idx_q <= fsk_pkg::BITS_PER_WORD)
		else $error("missing bit clock at data centre");
	a_idle_data_high:   assert property (!mode1 && cd_n_q |=> data_q) else $error("data not high without carrier");
	a_no_load_idle:     assert property (cd_n_q && mode1 |=> $stable(shift_q) || $past(shift_go))
		else $error("shift register loaded without carrier");
	a_load_ready_low:   assert property (m1_load |=> !ready_n_q && shift_q == $past(word_next))
		else $error("mode 1 load did not assert word-ready");
	a_first_read_rel:   assert property (!ready_n_q && host_rise && !m1_load |=> ready_n_q)
		else $error("host read did not release word-ready");
	a_self_release:     assert property (!ready_n_q && ready_end && !m1_load && !m0_done |=> ready_n_q)
		else $error("word-ready not released after half bit");
	a_extra_clk_ignored: assert property (mode1 && host_rise && remain_q == 4'h0 && !m1_load |=> $stable(data_q))
		else $error("extra read clock changed data");
	a_carrier_release:  assert property (!cd_n_q && tick && !energy && cd_cnt_q == fsk_pkg::CD_HOLD_LAST |=> cd_n_q)
		else $error("carrier not released after hold");
	a_pd_tones_low:     assert property (halt |=> !raw_q && !qual_q) else $error("tone outputs active in power-down");

	c_mode0_word:  cover property (m0_done);
	c_mode1_load:  cover property (m1_load ##[1:1000] host_rise);
	c_carrier_on:  cover property ($fell(cd_n_q));
	c_bridge_drop: cover property (!cd_n_q && !energy ##1 energy && !cd_n_q);
endmodule // fsk_word_serial_output
`default_nettype wire

// File: bench/fsk_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module fsk_host_model #(
	parameter int BIT_CYC = 64
) (
	// clock
	input  wire logic        clk,
	// bench settings
	input  wire logic        mode,
	input  wire logic [7:0]  delay,
	input  wire logic [3:0]  npulses,
	// device pins
	input  wire logic        data,
	input  wire logic        dev_clk,
	input  wire logic        word_ready_n,
	output logic             host_clk,
	// what the host received
	output logic [9:0]       bits,
	output logic [15:0]      words,
	output logic [15:0]      pulses,
	output logic [15:0]      space_err
);
	int          cyc = 0;
	int          last = 0;
	logic        dq = 1'b0;
	logic        wq = 1'b0;
	logic        clk_q = 1'b0;
	logic [9:0]  bits0 = '0;
	logic [9:0]  bits1 = '0;
	logic [15:0] words0 = '0;
	logic [15:0] words1 = '0;
	logic [15:0] pulses_q = '0;
	logic [15:0] space_q = '0;

	// each mode keeps its own record; one driver per signal
	assign host_clk  = clk_q;
	assign bits      = mode ? bits1 : bits0;
	assign words     = words0 + words1;
	assign pulses    = pulses_q;
	assign space_err = space_q;

	// mode 0: sample pins on clk so edge timing is race free
	always @(posedge clk) begin
		cyc <= cyc + 1;
		dq  <= dev_clk;
		wq  <= word_ready_n;
		if (!mode && dev_clk && !dq) begin
			if (pulses_q % 8 != 0 && cyc - last != BIT_CYC) space_q <= space_q + 1'b1;
			bits0    <= {2'b00, data, bits0[7:1]};
			pulses_q <= pulses_q + 1'b1;
			last     <= cyc;
		end
		if (!mode && wq && !word_ready_n) words0 <= words0 + 1'b1;
	end

	// mode 1: read pulses, 5 cycles high and low, so the synchroniser sees them
	initial begin
		forever begin
			@(negedge word_ready_n);
			if (mode) begin
				repeat (delay) @(posedge clk);
				for (int i = 0; i < npulses; i++) begin
					clk_q <= 1'b1;
					repeat (5) @(posedge clk);
					bits1[i] <= data;
					clk_q <= 1'b0;
					repeat (5) @(posedge clk);
				end
				words1 <= words1 + 1'b1;
			end
		end
	end
endmodule // fsk_host_model
`default_nettype wire

// File: bench/tb_fsk_word_serial_output.sv
`timescale 1ns/100ps
`default_nettype none
module tb_fsk_word_serial_output;
	localparam int TK    = 4;
	localparam int BIT   = 16 * TK;
	localparam int LIMIT = 30000;
	logic        CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA;
	logic        DEMOD_BIT, FSK_BAND_ENERGY, TONE_LOW_PRESENT, TONE_HIGH_PRESENT, GUARD_TIME_NODE;
	logic        INTERFACE_SEL, DEMODULATOR_ENABLE, POWER_DOWN_IN, SERIAL_BIT_CLOCK_OUT, SERIAL_BIT_CLOCK_OE;
	logic        SERIAL_DATA, WORD_READY_N, CARRIER_PRESENT_N, RAW_TONE_DETECT, QUALIFIED_TONE_DETECT;
	logic        CALL_ALERT_IN, CALL_ALERT_TIMING, CALL_ALERT_DISCHARGE, CALL_ALERT_OUT_N, INT_OUT, INT_OE;
	logic        host_clk;
	logic        int_low = 1'b0;
	logic [7:0]  delay, lfsr;
	logic [3:0]  npulses;
	logic [9:0]  bits;
	logic [15:0] words, pulses, space_err;
	int          error_cnt = 0, comparisons = 0, cycles = 0, falls = 0, lowc = 0, last_low = 0;
	wire         sclk_pin;

	// clock pin level: device drives it only while its enable is high
	assign sclk_pin = SERIAL_BIT_CLOCK_OE ? SERIAL_BIT_CLOCK_OUT : host_clk;

	fsk_word_serial_output #(.TICK_CYCLES(TK)) uut (.SERIAL_BIT_CLOCK_IN(sclk_pin), .*);

	fsk_host_model #(.BIT_CYC(BIT)) host (.clk(CLK), .mode(INTERFACE_SEL), .delay(delay), .npulses(npulses),
		.data(SERIAL_DATA), .dev_clk(SERIAL_BIT_CLOCK_OUT), .word_ready_n(WORD_READY_N), .host_clk(host_clk),
		.bits(bits), .words(words), .pulses(pulses), .space_err(space_err));

	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end

	// word-ready low time, pulse count and interrupt level while low
	always @(posedge CLK) begin
		cycles <= cycles + 1;
		if (WORD_READY_N === 1'b0) begin
			lowc <= lowc + 1;
			int_low <= INT_OE;
		end else if (lowc != 0) begin
			last_low <= lowc;
			falls <= falls + 1;
			lowc <= 0;
		end
		if (cycles == LIMIT) begin
			error_cnt++;
			summarize();
		end
	end

	function automatic logic [7:0] nxt(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task automatic chkb(input string nm, input logic e, input logic g);
		chk(nm, {31'h0, e}, {31'h0, g});
	endtask

	// one apb transfer: setup, then access until pready at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do @(posedge CLK); while (PREADY !== 1'b1);
		r = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		chk(nm, x, r);
	endtask

	task automatic wreg(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	// one character: start, eight data bits lsb first, stop
	task automatic send(input logic [7:0] b, input logic quiet);
		for (int i = 0; i < 10; i++) begin
			DEMOD_BIT <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
			repeat (BIT / 2) @(posedge CLK);
			if (quiet) chkb("idle data", 1'b1, SERIAL_DATA);
			repeat (BIT / 2) @(posedge CLK);
		end
	endtask

	task automatic wait_word(input logic [15:0] n);
		for (int k = 0; k < 300 && words != n; k++) @(posedge CLK);
		chk("word count", {16'h0000, n}, {16'h0000, words});
	endtask

	task automatic summarize();
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	initial begin
		logic [31:0] r;
		logic        e;
		int          f;
		{RST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA, FSK_BAND_ENERGY} = '0;
		{TONE_LOW_PRESENT, TONE_HIGH_PRESENT, GUARD_TIME_NODE, INTERFACE_SEL, POWER_DOWN_IN} = '0;
		CALL_ALERT_IN = 1'b0;
		{DEMOD_BIT, DEMODULATOR_ENABLE, CALL_ALERT_TIMING} = 3'b111;
		delay = 8'h00;
		npulses = 4'hA;
		lfsr = 8'h38;
		repeat (16) @(posedge CLK);
		RST_N <= 1'b1;
		rchk("ctrl reset", fsk_pkg::REG_CTRL, {31'h0, fsk_pkg::CTRL_RESET});
		apb(1'b0, 12'h010, 32'h0000_0000, r, e);
		chkb("unmapped err", 1'b1, e);
		wreg(fsk_pkg::REG_COUNT, 32'h0000_0000);
		$display("done: registers");
		// carrier qualify, bridge a dropout, then release
		FSK_BAND_ENERGY <= 1'b1;
		repeat (10 * TK) @(posedge CLK);
		chkb("cd early", 1'b1, CARRIER_PRESENT_N);
		repeat (20 * TK) @(posedge CLK);
		chkb("cd on", 1'b0, CARRIER_PRESENT_N);
		FSK_BAND_ENERGY <= 1'b0;
		repeat (100 * TK) @(posedge CLK);
		FSK_BAND_ENERGY <= 1'b1;
		repeat (5 * TK) @(posedge CLK);
		FSK_BAND_ENERGY <= 1'b0;
		repeat (140 * TK) @(posedge CLK);
		chkb("cd bridged", 1'b0, CARRIER_PRESENT_N);
		repeat (20 * TK) @(posedge CLK);
		chkb("cd released", 1'b1, CARRIER_PRESENT_N);
		chkb("mode0 oe", 1'b1, SERIAL_BIT_CLOCK_OE);
		f = falls;
		send(8'h00, 1'b1);
		chk("quiet ready", f, falls);
		chk("quiet clocks", 0, pulses);
		$display("done: carrier");
		// mode 0 traffic, back to back characters
		FSK_BAND_ENERGY <= 1'b1;
		repeat (30 * TK) @(posedge CLK);
		for (int n = 1; n <= 4; n++) begin
			lfsr = nxt(lfsr);
			send(lfsr, 1'b0);
			wait_word(16'(n));
			chk("mode0 word", lfsr, bits[7:0]);
			chk("mode0 clocks", 8 * n, pulses);
		end
		chk("clock spacing", 0, space_err);
		// the last word-ready is still low as the stop bit ends; let it release
		repeat (BIT) @(posedge CLK);
		chk("mode0 ready", f + 4, falls);
		rchk("word reg", fsk_pkg::REG_WORD, {24'h0, lfsr});
		rchk("count reg", fsk_pkg::REG_COUNT, 32'h0000_0004);
		wreg(fsk_pkg::REG_CTRL, 32'h0000_0000);
		send(8'h5A, 1'b0);
		chk("disabled", f + 4, falls);
		wreg(fsk_pkg::REG_CTRL, 32'h0000_0001);
		$display("done: mode0");
		// mode 1, prompt host with surplus clocks, then a slow host
		INTERFACE_SEL <= 1'b1;
		repeat (BIT) @(posedge CLK);
		chkb("mode1 oe", 1'b0, SERIAL_BIT_CLOCK_OE);
		for (int n = 0; n < 4; n++) begin
			delay <= (n == 3) ? 8'd60 : 8'd0;
			f = words;
			lfsr = nxt(lfsr);
			send(lfsr, 1'b0);
			wait_word(16'(f + 1));
			chk("mode1 word", lfsr, bits[7:0]);
			chk("extra clocks", {2{lfsr[7]}}, bits[9:8]);
			if (n < 3) chkb("ready by clock", 1'b1, last_low <= 8);
		end
		chkb("ready timeout", 1'b1, last_low >= BIT / 2 && last_low <= BIT / 2 + TK + 2);
		chkb("ready int", 1'b1, int_low);
		rchk("status", fsk_pkg::REG_STATUS, 32'h0000_0003);
		FSK_BAND_ENERGY <= 1'b0;
		repeat (170 * TK) @(posedge CLK);
		f = falls;
		send(8'hC3, 1'b0);
		chk("mode1 no carrier", f, falls);
		$display("done: mode1");
		// tone detect, power-down and the alert path
		{TONE_LOW_PRESENT, TONE_HIGH_PRESENT, GUARD_TIME_NODE} <= 3'b111;
		repeat (10) @(posedge CLK);
		chkb("raw tone", 1'b1, RAW_TONE_DETECT);
		chkb("qual tone", 1'b1, QUALIFIED_TONE_DETECT);
		chkb("tone int", 1'b1, INT_OE);
		POWER_DOWN_IN <= 1'b1;
		FSK_BAND_ENERGY <= 1'b1;
		repeat (30 * TK) @(posedge CLK);
		chkb("pd raw", 1'b0, RAW_TONE_DETECT);
		chkb("pd qual", 1'b0, QUALIFIED_TONE_DETECT);
		chkb("pd carrier", 1'b1, CARRIER_PRESENT_N);
		CALL_ALERT_TIMING <= 1'b0;
		CALL_ALERT_IN <= 1'b1;
		repeat (10) @(posedge CLK);
		chkb("alert out", 1'b0, CALL_ALERT_OUT_N);
		chkb("discharge", 1'b1, CALL_ALERT_DISCHARGE);
		chkb("alert int", 1'b1, INT_OE);
		{CALL_ALERT_TIMING, CALL_ALERT_IN, POWER_DOWN_IN, INTERFACE_SEL} <= 4'b1000;
		{TONE_LOW_PRESENT, TONE_HIGH_PRESENT, GUARD_TIME_NODE} <= 3'b000;
		repeat (30 * TK) @(posedge CLK);
		chkb("int idle", 1'b0, INT_OE);
		chkb("int out", 1'b0, INT_OUT);
		f = words;
		lfsr = nxt(lfsr);
		send(lfsr, 1'b0);
		wait_word(16'(f + 1));
		chk("resume word", lfsr, bits[7:0]);
		DEMODULATOR_ENABLE <= 1'b0;
		$display("done: power-down");
		summarize();
	end
endmodule // tb_fsk_word_serial_output
`default_nettype wire
